/* hw/osv_pkg.sv */
// Package for the output status indicator voter: sizes, thresholds,
// indicator modes, channel states, default mode map and carrier structs.
// Assumes a single 40 MHz clock and 8-bit field measurement codes.
package osv_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NCH = 40;                // Field output channels
  localparam int NSL = 3;                 // Redundant slices
  localparam int MW  = 8;                 // Measurement code width

  ////////////////////////////////////////////////////////////////////////
  // Fault thresholds in measurement codes
  localparam logic [MW-1:0] OSV_I_SHORT = 8'hc0; // Overcurrent trip
  localparam logic [MW-1:0] OSV_I_OPEN  = 8'h08; // Below: no load
  localparam logic [MW-1:0] OSV_V_SUP   = 8'h40; // Below: no supply

  ////////////////////////////////////////////////////////////////////////
  // Blink timebase
  localparam int OSV_CLK_HZ   = 40_000_000;
  localparam int OSV_BLINK_MS = 250;      // Half period of flashing
  localparam int OSV_BLINK_CYC = OSV_CLK_HZ / 1000 * OSV_BLINK_MS;
  localparam int OSV_BCW      = 24;       // Blink counter width

  ////////////////////////////////////////////////////////////////////////
  // Channel output states and indicator modes
  typedef enum logic [2:0] {
    OSV_ST_OFF, OSV_ST_ON, OSV_ST_OPEN, OSV_ST_SHORT, OSV_ST_FAULT
  } osv_state_t;

  typedef enum logic [2:0] {
    OSV_LED_OFF, OSV_LED_GREEN, OSV_LED_RED, OSV_LED_FGREEN, OSV_LED_FRED
  } osv_led_t;

  localparam int OSV_MAPW = 15;           // Five states, three bits each
  // Default map suits line-monitored loads, indexed by state code
  localparam logic [OSV_MAPW-1:0] OSV_DEF_MAP = {
    3'(OSV_LED_FRED), 3'(OSV_LED_RED), 3'(OSV_LED_FGREEN),
    3'(OSV_LED_GREEN), 3'(OSV_LED_OFF)};

  ////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [NCH-1:0] cmd;                  // Commanded on per channel
    logic           fault;                // Slice self-diagnosed fault
  } osv_slice_t;

  typedef struct packed {
    logic [MW-1:0] volt;
    logic [MW-1:0] cur;
  } osv_meas_t;

endpackage : osv_pkg

/* hw/osv_top.sv */
// Output status indicator voter: votes the three slice words, classifies
// each channel from its measured voltage and current, maps the state to
// an indicator mode and drives the bicolour and slice health indicators.
// Assumes slice words and measurements arrive asynchronously on pins and
// the mode map and its select come from logic on clk.
`timescale 1ns/1ps

module osv_top
  import osv_pkg::*;
#(
  parameter int BLINK_CYC = OSV_BLINK_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire osv_slice_t [NSL-1:0]  slice_in,
  input  wire osv_meas_t  [NCH-1:0]  meas_in,
  input  wire logic                  map_custom,
  input  wire logic [OSV_MAPW-1:0]   map_cfg,
  output logic [NCH-1:0]             out_drive,
  output osv_state_t [NCH-1:0]       chan_state,
  output logic [NCH-1:0]             line_fault,
  output osv_meas_t  [NCH-1:0]       meas_out,
  output logic [NCH-1:0]             led_green,
  output logic [NCH-1:0]             led_red,
  output logic [NSL-1:0]             hlth_green,
  output logic [NSL-1:0]             hlth_red,
  output logic [NSL-1:0]             module_status_a
);

  //////////////////////////////////////////////////////////////////////////
  // Functions

  // Bitwise majority of three words
  function automatic logic [NCH-1:0] vote3(input logic [NCH-1:0] a,
                                           input logic [NCH-1:0] b,
                                           input logic [NCH-1:0] c);
    return (a & b) | (a & c) | (b & c);
  endfunction : vote3

  // Mode for one state out of a packed map
  function automatic osv_led_t led_of(input logic [OSV_MAPW-1:0] m,
                                      input osv_state_t s);
    return osv_led_t'(m[3*int'(s) +: 3]);
  endfunction : led_of

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  osv_slice_t [NSL-1:0] slice_s1_reg;
  osv_slice_t [NSL-1:0] slice_s2_reg;
  osv_meas_t  [NCH-1:0] meas_s1_reg;
  osv_meas_t  [NCH-1:0] meas_s2_reg;

  // Two stages; only the second is read by logic
  always_ff @(posedge clk) begin
    if (!rstn) begin
      slice_s1_reg <= '0;
      slice_s2_reg <= '0;
      meas_s1_reg  <= '0;
      meas_s2_reg  <= '0;
    end else begin
      slice_s1_reg <= slice_in;
      slice_s2_reg <= slice_s1_reg;
      meas_s1_reg  <= meas_in;
      meas_s2_reg  <= meas_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Vote and map select

  logic [NCH-1:0]      v_cmd;
  logic [OSV_MAPW-1:0] map_act;
  logic [NSL-1:0]      sl_fault;

  // One bad slice is outvoted, so outputs keep running
  assign v_cmd = vote3(slice_s2_reg[0].cmd, slice_s2_reg[1].cmd,
                       slice_s2_reg[2].cmd);
  assign map_act = map_custom ? map_cfg : OSV_DEF_MAP;
  assign sl_fault = {slice_s2_reg[2].fault, slice_s2_reg[1].fault,
                     slice_s2_reg[0].fault};

  //////////////////////////////////////////////////////////////////////////
  // Blink timebase

  logic [OSV_BCW-1:0] blink_cnt_reg;
  logic               blink_reg;
  logic               blink_wrap;

  assign blink_wrap = blink_cnt_reg == OSV_BCW'(BLINK_CYC - 1);

  // Single phase shared by every flashing indicator
  always_ff @(posedge clk) begin
    if (!rstn) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt_reg <= '0;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-channel classification, wholly local to its own channel

  logic [NCH-1:0]       short_reg;
  logic [NCH-1:0]       short_next;
  logic [NCH-1:0]       drive_next;
  logic [NCH-1:0]       fault_next;
  logic [NCH-1:0]       green_next;
  logic [NCH-1:0]       red_next;
  osv_state_t [NCH-1:0] state_next;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic       over_i;
    logic       low_sup;
    logic       leak;
    logic       no_load;
    osv_state_t st_n;
    osv_led_t   md;

    // Faults judged from this channel's own measurements only
    assign over_i  = v_cmd[i] && meas_s2_reg[i].cur >= OSV_I_SHORT;
    assign low_sup = v_cmd[i] && meas_s2_reg[i].volt < OSV_V_SUP;
    assign leak    = !v_cmd[i] && meas_s2_reg[i].cur > OSV_I_OPEN;
    assign no_load = v_cmd[i] && meas_s2_reg[i].cur < OSV_I_OPEN;
    // Latch holds until the command drops, so a short cannot chatter
    assign short_next[i] = v_cmd[i] & (short_reg[i] | over_i);
    assign st_n = short_next[i]     ? OSV_ST_SHORT :
                  (low_sup || leak) ? OSV_ST_FAULT :
                  no_load           ? OSV_ST_OPEN  :
                  v_cmd[i]          ? OSV_ST_ON    :
                                      OSV_ST_OFF;
    assign state_next[i] = st_n;
    assign drive_next[i] = v_cmd[i] & ~short_next[i];
    assign fault_next[i] = st_n != OSV_ST_OFF && st_n != OSV_ST_ON;
    assign md = led_of(map_act, st_n);
    assign green_next[i] = md == OSV_LED_GREEN ||
                           (md == OSV_LED_FGREEN && blink_reg);
    assign red_next[i]   = md == OSV_LED_RED ||
                           (md == OSV_LED_FRED && blink_reg);
  end

  //////////////////////////////////////////////////////////////////////////
  // Output registers

  // Channel outputs and indicators
  always_ff @(posedge clk) begin
    if (!rstn) begin
      short_reg  <= '0;
      out_drive  <= '0;
      chan_state <= '{default: OSV_ST_OFF};
      line_fault <= '0;
      meas_out   <= '0;
      led_green  <= '0;
      led_red    <= '0;
    end else begin
      short_reg  <= short_next;
      out_drive  <= drive_next;
      chan_state <= state_next;
      line_fault <= fault_next;
      meas_out   <= meas_s2_reg;
      led_green  <= green_next;
      led_red    <= red_next;
    end
  end

  // Health indicators straight from each slice, bypassing the vote
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hlth_green      <= '0;
      hlth_red        <= '0;
      module_status_a <= '0;
    end else begin
      hlth_green      <= ~sl_fault;
      hlth_red        <= sl_fault & {NSL{blink_reg}};
      module_status_a <= sl_fault;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_led_one_colour: assert property (
    (led_green & led_red) == '0)
    else $error("indicator lit green and red at once");

  chk_vote_drive: assert property (
    (out_drive & ~$past(v_cmd)) == '0)
    else $error("output driven without a majority");

  chk_default_on: assert property (
    $past(!map_custom) && chan_state[0] == OSV_ST_ON
    |-> led_green[0] && !led_red[0])
    else $error("default on state not steady green");

  chk_open_flash: assert property (
    $past(!map_custom) && chan_state[0] == OSV_ST_OPEN
    |-> led_green[0] == $past(blink_reg) && !led_red[0])
    else $error("default open load not flashing green");

  chk_short_off: assert property (
    chan_state[0] == OSV_ST_SHORT |-> !out_drive[0] ##1
    (!out_drive[0] || $past(!v_cmd[0], 2)))
    else $error("shorted channel driven");

  chk_fault_flash: assert property (
    $past(!map_custom) && chan_state[0] == OSV_ST_FAULT
    |-> led_red[0] == $past(blink_reg) && !led_green[0])
    else $error("default fault not flashing red");

  chk_meas_copy: assert property (
    meas_out == $past(meas_s2_reg))
    else $error("measurement not published");

  chk_line_flag: assert property (
    line_fault[0] == (chan_state[0] inside
      {OSV_ST_OPEN, OSV_ST_SHORT, OSV_ST_FAULT}))
    else $error("line fault flag disagrees with state");

  chk_short_release: assert property (
    $past(!v_cmd[0]) |-> chan_state[0] != OSV_ST_SHORT)
    else $error("short latch survives command off");

  chk_health_led: assert property (
    $past(rstn) |-> // Skip the edge leaving reset, lamps still dark
    hlth_green == ~$past(sl_fault) &&
    hlth_red == ($past(sl_fault) & {NSL{$past(blink_reg)}}))
    else $error("health indicator wrong");

  chk_blink_phase: assert property (
    $changed(blink_reg) |-> $past(blink_wrap))
    else $error("blink toggled off the shared timebase");

  // Custom map: on state set to steady red must show red only
  chk_custom_map: assert property (
    $past(map_custom && map_cfg[5:3] == 3'(OSV_LED_RED)) &&
    chan_state[0] == OSV_ST_ON |-> led_red[0] && !led_green[0])
    else $error("custom map not applied to on state");

  // Two agreeing slices decide the drive, whatever the third says
  chk_outvote_runs: assert property (
    $past(slice_s2_reg[0].cmd == slice_s2_reg[1].cmd) |->
    (out_drive | $past(short_next)) == $past(slice_s2_reg[0].cmd))
    else $error("drive lost with one slice dissenting");

  // An idle channel stays quiet while its neighbours fault
  chk_chan_isolate: assert property (
    $past(!v_cmd[2] && meas_s2_reg[2].cur <= OSV_I_OPEN) |->
    chan_state[2] == OSV_ST_OFF && !line_fault[2])
    else $error("idle channel disturbed");

  // Red health only follows that slice's own fault
  chk_health_own: assert property (
    hlth_red[0] |-> $past(slice_s2_reg[0].fault) && !hlth_green[0])
    else $error("health indicator not owned by its slice");

  // Clean measurements on a driven channel read back as plain on
  chk_clear_on: assert property (
    $past(v_cmd[0] && !short_reg[0] &&
          meas_s2_reg[0].volt >= OSV_V_SUP &&
          meas_s2_reg[0].cur >= OSV_I_OPEN &&
          meas_s2_reg[0].cur < OSV_I_SHORT) |->
    chan_state[0] == OSV_ST_ON && !line_fault[0])
    else $error("cleared channel not back to on");

  // Overcurrent while commanded latches off and raises the flag
  chk_short_flag: assert property (
    $past(v_cmd[0] && meas_s2_reg[0].cur >= OSV_I_SHORT) |->
    chan_state[0] == OSV_ST_SHORT && line_fault[0] && !out_drive[0])
    else $error("overcurrent did not latch the channel off");

  // Main scenarios worth seeing at least once

  cov_short: cover property (chan_state[0] == OSV_ST_SHORT
    ##[1:20] chan_state[0] == OSV_ST_OFF);
  cov_open: cover property (chan_state[0] == OSV_ST_OPEN);
  cov_outvote: cover property (slice_s2_reg[0].cmd[0] !=
    slice_s2_reg[1].cmd[0] ##3 out_drive[0]);
  cov_slice_fault: cover property (hlth_red != '0);
  cov_custom: cover property (map_custom && led_red[0] &&
    chan_state[0] == OSV_ST_ON);

endmodule : osv_top

/* tb/osv_field_load.sv */
// Behavioural field loads and wiring for the indicator voter bench.
// Assumes the voted drive per channel and a fault kind set by the bench.
`timescale 1ns/1ps
module osv_field_load
  import osv_pkg::*;
(
  input  wire logic [NCH-1:0] drive,
  input  wire logic [2:0]     fk [NCH],
  output osv_meas_t [NCH-1:0] meas
);
  ////////////////////////////////////////////////////////////////////////
  // Kinds: 0 healthy, 1 open, 2 short, 3 no supply, 4 leakage.
  // An undriven terminal is pulled down, so it never shows a stale level.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      meas[i].volt = (drive[i] && fk[i] != 3'h3) ? 8'h80 : 8'h00;
      meas[i].cur  = 8'h00;
      if (drive[i] && fk[i] == 3'h0) meas[i].cur = 8'h40;
      if (drive[i] && fk[i] == 3'h2) meas[i].cur = 8'hff; // Trips the latch
      if (fk[i] == 3'h4) meas[i].cur = 8'h20; // Leaks even when off
    end
  end
endmodule : osv_field_load

/* tb/osv_top_tb.sv */
// Self-checking bench for osv_top: vote, maps, field faults, health.
// Assumes osv_field_load closes the loop from drive to measurement.
`timescale 1ns/1ps
module osv_top_tb
  import osv_pkg::*;
;
  localparam int BC = 8;
  localparam logic [39:0] P = 40'ha55af00fc3;
  // Led folds {g any, g all, r any, r all} per mode code
  localparam logic [3:0] LX [5] = '{4'h0, 4'hc, 4'h3, 4'h8, 4'h2};
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  osv_slice_t [NSL-1:0] sl;
  osv_meas_t [NCH-1:0]  meas;
  osv_meas_t [NCH-1:0]  meas_out;
  osv_state_t [NCH-1:0] chan_state;
  logic                 map_custom;
  logic [OSV_MAPW-1:0]  map_cfg;
  logic [2:0]           fk [NCH];
  logic [NCH-1:0]       out_drive, line_fault, led_green, led_red;
  logic [NSL-1:0]       hlth_green, hlth_red, module_status_a;
  int                   err_total = 0;
  int                   checked = 0;
  int                   cyc = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  osv_top #(.BLINK_CYC(BC)) dut (.clk(clk), .rstn(rstn), .slice_in(sl),
    .meas_in(meas), .map_custom(map_custom), .map_cfg(map_cfg),
    .out_drive(out_drive), .chan_state(chan_state),
    .line_fault(line_fault), .meas_out(meas_out), .led_green(led_green),
    .led_red(led_red), .hlth_green(hlth_green), .hlth_red(hlth_red),
    .module_status_a(module_status_a));
  osv_field_load load (.drive(out_drive), .fk(fk), .meas(meas));

  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Three blink half periods so a flashing mode shows both phases
  task automatic chk_led(input int ch, input int hs, input logic [3:0] e);
    logic [3:0] a;
    logic       g, r;
    a = 4'h5;
    repeat (3 * BC) begin
      g = hs < 0 ? led_green[ch] : hlth_green[hs];
      r = hs < 0 ? led_red[ch] : hlth_red[hs];
      a = {a[3] | g, a[2] & g, a[1] | r, a[0] & r};
      step(1);
    end
    chk(64'(a), 64'(e));
  endtask : chk_led

  ////////////////////////////////////////////////////////////////////////
  // One dissenting, self-faulted slice per pass
  task automatic t_vote();
    for (int k = 0; k < NSL; k++) begin
      for (int j = 0; j < NSL; j++) sl[j] = {j == k ? ~P : P, j == k};
      step(12);
      chk(64'(out_drive), 64'(P));
      chk(64'(module_status_a), 64'(1 << k));
      chk_led(0, k, LX[4]);
      chk_led(0, (k + 1) % NSL, LX[1]);
    end
    for (int j = 0; j < NSL; j++) sl[j] = {P, 1'b0};
    step(12);
  endtask : t_vote

  task automatic t_default();
    chk(64'(led_green), 64'(P));
    chk(64'(led_red), 64'h0);
    chk(64'(chan_state[2]), 64'(OSV_ST_OFF));
    chk(64'(meas_out[0]), 64'h8040);
    chk_led(2, -1, LX[0]);
  endtask : t_default

  task automatic t_fault(input int ch, input logic [2:0] k,
                         input osv_state_t st, input int md);
    fk[ch] = k;
    step(12);
    chk(64'(chan_state[ch]), 64'(st));
    chk(64'(line_fault), 64'h1 << ch);
    chk(64'(out_drive), 64'(P & ~(40'(k == 3'h2) << ch)));
    chk_led(ch, -1, LX[md]);
    fk[ch] = 3'h0;
    // The short latch only lets go once the command is recycled
    for (int j = 0; j < NSL; j++) sl[j].cmd[ch] = 1'b0;
    step(6);
    for (int j = 0; j < NSL; j++) sl[j].cmd[ch] = P[ch];
    step(12);
    chk(64'(chan_state[ch]), 64'(P[ch] ? OSV_ST_ON : OSV_ST_OFF));
    chk(64'(line_fault), 64'h0);
  endtask : t_fault

  task automatic t_custom();
    map_custom = 1'b1;
    for (int m = 0; m < 5; m++) begin
      map_cfg = {5{3'(m)}};
      step(4);
      chk_led(0, -1, LX[m]);
      repeat (m == 3 ? 2 * BC : 0) begin
        chk(64'(led_green == '0 || led_green == '1), 64'h1);
        step(1);
      end
    end
    map_cfg = 15'h0010;
    step(4);
    chk_led(0, -1, LX[2]);
    map_custom = 1'b0;
    step(4);
  endtask : t_custom

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Summary: checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    sl = '0;
    map_custom = 1'b0;
    map_cfg = '0;
    for (int i = 0; i < NCH; i++) fk[i] = 3'h0;
    step(3);
    rstn = 1'b1;
    t_vote();
    t_default();
    t_fault(0, 3'h1, OSV_ST_OPEN, 3);
    t_fault(0, 3'h2, OSV_ST_SHORT, 2);
    t_fault(0, 3'h3, OSV_ST_FAULT, 4);
    t_fault(2, 3'h4, OSV_ST_FAULT, 4);
    t_custom();
    stop_test();
  end
endmodule : osv_top_tb
